// [hw/ahp_defines.svh]
// Constants of the asynchronous host bus port
`ifndef AHP_DEFINES_SVH
`define AHP_DEFINES_SVH
`define AHP_DATA_W        32
`define AHP_REG_W         16
`define AHP_ADDR_LO       2
`define AHP_ADDR_HI       5
`define AHP_ADDR_W        4
`define AHP_NUM_IRQ       3
`define AHP_NUM_EVT       8
`define AHP_NUM_TIO       4
`define AHP_NUM_TPO       4
`define AHP_MODE_RST      1'b0
`define AHP_WIDE_RST      1'b0
`define AHP_LITTLE_RST    1'b0
`define AHP_SYNC_RST      3'b000
`endif

// [hw/ahp_pkg.sv]
// Types of the asynchronous host bus port
package ahp_pkg;
   typedef enum logic [3:0] {
      AHP_IDLE  = 4'b0001,
      AHP_ADDR  = 4'b0010,
      AHP_READ  = 4'b0100,
      AHP_WRITE = 4'b1000
   } ahp_state_type;
endpackage : ahp_pkg

// [hw/ahp_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
`include "ahp_defines.svh"
module ahp_sync (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic pin_i,
   output var  logic level_o
);
   logic [2:0] stage_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage_q <= `AHP_SYNC_RST;
         level_o <= 1'b0;
      end else begin
         stage_q <= {stage_q[1:0], pin_i};
         if (stage_q[2] == stage_q[1]) begin
            level_o <= stage_q[2];
         end
      end
   end
endmodule : ahp_sync
`default_nettype wire

// [hw/ahp_lanes.sv]
// Byte lane ordering for queue data; register data always in low 16 bits
`timescale 1ns/10ps
`default_nettype none
`include "ahp_defines.svh"
module ahp_lanes (
   input  wire logic        wide_i,
   input  wire logic        little_i,
   input  wire logic        is_reg_i,
   input  wire logic [31:0] data_i,
   output logic      [31:0] data_o
);
   // Byte array order: first byte in low lane when little endian
   function automatic logic [31:0] swap_fn(input logic [31:0] d,
                                           input logic        w);
      swap_fn = w ? {d[7:0], d[15:8], d[23:16], d[31:24]}
                  : {16'h0000, d[7:0], d[15:8]};
   endfunction : swap_fn
   wire logic [31:0] reg_data;
   wire logic [31:0] q_data;
   assign reg_data = {16'h0000, data_i[15:0]};
   assign q_data   = little_i ? (wide_i ? data_i : {16'h0000, data_i[15:0]})
                              : swap_fn(data_i, wide_i);
   assign data_o   = is_reg_i ? reg_data : q_data;
endmodule : ahp_lanes
`default_nettype wire

// [hw/ahp_host_port.sv]
// Asynchronous parallel host bus port, device side
`timescale 1ns/10ps
`default_nettype none
`include "ahp_defines.svh"
module ahp_host_port
   import ahp_pkg::*;
(
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     bus_mux_select_i,
   input  wire logic                     byte_order_select_i,
   input  wire logic                     width_select_i,
   input  wire logic                     chip_sel_n_i,
   input  wire logic                     out_en_n_i,
   input  wire logic                     write_en_n_i,
   input  wire logic                     addr_bit2_or_latch_i,
   input  wire logic [2:0]               addr_bit3_line_i,
   input  wire logic [31:0]              data_i,
   output logic      [31:0]              data_o,
   output logic                          data_oe_o,
   input  wire logic                     queue_sel_i,
   output logic      [3:0]               addr_o,
   output logic                          wr_strobe_o,
   output logic      [31:0]              wr_data_o,
   output logic                          rd_strobe_o,
   input  wire logic [31:0]              rd_data_i,
   output logic                          bus_mux_o,
   output logic                          bus_wide_o,
   output logic                          little_endian_o,
   input  wire logic [7:0]               event_i,
   input  wire logic [23:0]              irq_select_i,
   output logic                          host_irq_0_o,
   output logic                          host_irq_1_o,
   output logic                          host_irq_2_o,
   input  wire logic [3:0]               timebase_dir_out_i,
   input  wire logic [3:0]               timebase_pin_out_i,
   input  wire logic [3:0]               timebase_pin_i,
   output logic      [3:0]               timebase_pin_o,
   output logic      [3:0]               timebase_pin_oe_o,
   output logic      [3:0]               timebase_pin_in_o,
   input  wire logic                     timebase_tick_i,
   input  wire logic [3:0]               timebase_pulse_d_i,
   output logic      [3:0]               timebase_pulse_out_o
);
   logic             strap_armed_q;
   logic             mux_q;
   logic             wide_q;
   logic             little_q;
   ahp_state_type    state_q;
   ahp_state_type    state_d;
   logic             cs_n_s;
   logic             oe_n_s;
   logic             we_n_s;
   logic             ale_s;
   logic             cs_n_prev_q;
   logic             ale_prev_q;
   logic [3:0]       addr_q;
   logic [31:0]      rdata_q;
   logic [31:0]      dsync1_q;
   logic [31:0]      dsync2_q;
   logic [31:0]      dsync3_q;
   logic [31:0]      dsync4_q;
   logic [31:0]      dsync5_q;
   logic             addr_done_q;
   logic [2:0]       irq_q;
   logic [3:0]       tpo_q;

   ahp_sync u_cs  (.clk_i(clk_i), .rst_n_i(rst_n_i),
                   .pin_i(chip_sel_n_i), .level_o(cs_n_s));
   ahp_sync u_oe  (.clk_i(clk_i), .rst_n_i(rst_n_i),
                   .pin_i(out_en_n_i), .level_o(oe_n_s));
   ahp_sync u_we  (.clk_i(clk_i), .rst_n_i(rst_n_i),
                   .pin_i(write_en_n_i), .level_o(we_n_s));
   ahp_sync u_ale (.clk_i(clk_i), .rst_n_i(rst_n_i),
                   .pin_i(addr_bit2_or_latch_i), .level_o(ale_s));

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_tio
         ahp_sync u_tin (.clk_i(clk_i), .rst_n_i(rst_n_i),
                         .pin_i(timebase_pin_i[gi]),
                         .level_o(timebase_pin_in_o[gi]));
      end
   endgenerate

   // Strap capture on first clock after reset release
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_armed_q <= 1'b1;
         mux_q         <= `AHP_MODE_RST;
         wide_q        <= `AHP_WIDE_RST;
         little_q      <= `AHP_LITTLE_RST;
      end else if (strap_armed_q) begin
         strap_armed_q <= 1'b0;
         mux_q         <= bus_mux_select_i;
         wide_q        <= width_select_i;
         little_q      <= byte_order_select_i;
      end
   end
   assign bus_mux_o       = mux_q;
   assign bus_wide_o      = wide_q;
   assign little_endian_o = little_q;

   // Data pins: three sync stages, two more to match strobe filter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dsync1_q <= 32'h0000_0000;
         dsync2_q <= 32'h0000_0000;
         dsync3_q <= 32'h0000_0000;
         dsync4_q <= 32'h0000_0000;
         dsync5_q <= 32'h0000_0000;
      end else begin
         dsync1_q <= data_i;
         dsync2_q <= dsync1_q;
         dsync3_q <= dsync2_q;
         dsync4_q <= dsync3_q;
         dsync5_q <= dsync4_q;
      end
   end

   wire logic cs_fall;
   wire logic cs_rise;
   wire logic ale_fall;
   wire logic [3:0] sep_addr;
   wire logic [3:0] mux_addr;
   wire logic       rd_end;
   wire logic       addr_ok;
   assign cs_fall  = cs_n_prev_q & ~cs_n_s;
   assign cs_rise  = ~cs_n_prev_q & cs_n_s;
   assign ale_fall = ale_prev_q & ~ale_s;
   // Separate mode: pins 3..5 plus bit 2; multiplexed ignores them
   assign sep_addr = {addr_bit3_line_i, addr_bit2_or_latch_i};
   assign mux_addr = dsync5_q[5:2];
   assign rd_end   = cs_n_s | oe_n_s;
   assign addr_ok  = ~mux_q | addr_done_q | ale_fall;

   always_comb begin
      state_d = state_q;
      case (state_q)
         AHP_IDLE: begin
            if (cs_fall) begin
               state_d = AHP_ADDR;
            end
         end
         // Direction waits for write or output enable to fall
         AHP_ADDR: begin
            if (cs_n_s) begin
               state_d = AHP_IDLE;
            end else if (addr_ok & ~we_n_s) begin
               state_d = AHP_WRITE;
            end else if (addr_ok & ~oe_n_s) begin
               state_d = AHP_READ;
            end
         end
         AHP_READ: begin
            if (rd_end) begin
               state_d = AHP_IDLE;
            end
         end
         AHP_WRITE: begin
            if (cs_n_s | we_n_s) begin
               state_d = AHP_IDLE;
            end
         end
         default: state_d = AHP_IDLE;
      endcase
   end

   wire logic [31:0] wr_ordered;
   wire logic [31:0] rd_ordered;
   ahp_lanes u_wlanes (.wide_i(wide_q), .little_i(little_q),
                       .is_reg_i(~queue_sel_i), .data_i(dsync5_q),
                       .data_o(wr_ordered));
   ahp_lanes u_rlanes (.wide_i(wide_q), .little_i(little_q),
                       .is_reg_i(~queue_sel_i), .data_i(rd_data_i),
                       .data_o(rd_ordered));

   wire logic wr_fire;
   wire logic rd_fire;
   assign wr_fire = (state_q == AHP_WRITE) & (cs_n_s | we_n_s);
   assign rd_fire = (state_d == AHP_READ) & (state_q != AHP_READ);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q     <= AHP_IDLE;
         cs_n_prev_q <= 1'b0;   // Synchroniser reset level, no false fall
         ale_prev_q  <= 1'b0;
         addr_q      <= 4'h0;
         addr_done_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         cs_n_prev_q <= cs_n_s;
         ale_prev_q  <= ale_s;
         if (state_q != AHP_ADDR) begin
            addr_done_q <= 1'b0;
         end else if (ale_fall) begin
            addr_done_q <= 1'b1;
         end
         if (cs_fall & ~mux_q) begin
            addr_q <= sep_addr;
         end else if (mux_q & (state_q == AHP_ADDR) & ale_fall) begin
            addr_q <= mux_addr;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q     <= 32'h0000_0000;
         wr_data_o   <= 32'h0000_0000;
         wr_strobe_o <= 1'b0;
         rd_strobe_o <= 1'b0;
      end else begin
         wr_strobe_o <= wr_fire;
         rd_strobe_o <= rd_fire;
         if (wr_fire) begin
            wr_data_o <= wr_ordered;
         end
         if (rd_strobe_o) begin
            rdata_q <= rd_ordered;
         end
      end
   end
   assign addr_o = addr_q;
   assign data_o = wide_q ? rdata_q : {16'h0000, rdata_q[15:0]};
   // Pin level is combined with the live enable to stay off the bus
   assign data_oe_o = (state_q == AHP_READ) & ~oe_n_s & ~out_en_n_i
                      & ~chip_sel_n_i;

   // Each interrupt OR of its own selected events
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= 3'b000;
      end else begin
         irq_q[0] <= |(event_i & irq_select_i[7:0]);
         irq_q[1] <= |(event_i & irq_select_i[15:8]);
         irq_q[2] <= |(event_i & irq_select_i[23:16]);
      end
   end
   assign host_irq_0_o = irq_q[0];
   assign host_irq_1_o = irq_q[1];
   assign host_irq_2_o = irq_q[2];

   // Timer pins: 0..3 per-pin direction, 4..7 on timebase tick
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tpo_q <= 4'h0;
      end else if (timebase_tick_i) begin
         tpo_q <= timebase_pulse_d_i;
      end
   end
   assign timebase_pin_o       = timebase_pin_out_i;
   assign timebase_pin_oe_o    = timebase_dir_out_i;
   assign timebase_pulse_out_o = tpo_q;

   sequence wr_ack_seq;
      wr_strobe_o ##1 !wr_strobe_o;
   endsequence : wr_ack_seq
   sequence rd_ack_seq;
      rd_strobe_o ##1 !rd_strobe_o;
   endsequence : rd_ack_seq

   AST_STRAP_HOLD: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      !strap_armed_q |=> $stable(mux_q) && $stable(wide_q)
                         && $stable(little_q))
      else $error("strap changed after capture");
   AST_STRAP_TAKE: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      strap_armed_q |=> mux_q == $past(bus_mux_select_i))
      else $error("mux strap not captured");
   AST_ENDIAN_TAKE: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      strap_armed_q |=> little_q == $past(byte_order_select_i))
      else $error("endian strap not captured");
   AST_OE_ONLY: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      out_en_n_i |-> !data_oe_o)
      else $error("data driven without output enable");
   AST_READ_END: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      (state_q == AHP_READ && rd_end) |=> state_q == AHP_IDLE)
      else $error("read not ended");
   AST_SEP_ADDR: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      (cs_fall && !mux_q) |=> addr_q == $past(sep_addr))
      else $error("address not latched on select fall");
   AST_WR_PULSE: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      wr_fire |=> wr_ack_seq)
      else $error("write strobe wrong");
   AST_NARROW: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      !wide_q |-> data_o[31:16] == 16'h0000)
      else $error("upper lanes driven on narrow bus");
   AST_CS_END: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      cs_rise |=> state_q == AHP_IDLE)
      else $error("select rise did not end access");
   AST_RD_PULSE: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      rd_fire |=> rd_ack_seq)
      else $error("read strobe wrong");
   AST_MUX_ADDR: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      (mux_q && state_q == AHP_ADDR && ale_fall)
         |=> addr_q == $past(mux_addr))
      else $error("multiplexed address not latched");
endmodule : ahp_host_port
`default_nettype wire

// [dv/ahp_host_model.sv]
// Host bus controller model
`timescale 1ns/10ps
`default_nettype none
module ahp_host_model (
   input  wire logic        clk_i,
   input  wire logic        mux_i,
   output logic             cs_n_o,
   output logic             oe_n_o,
   output logic             we_n_o,
   output logic             ale_o,
   output logic      [2:0]  a35_o,
   output logic      [31:0] dq_o
);
   initial begin
      cs_n_o = 1'b1;
      oe_n_o = 1'b1;
      we_n_o = 1'b1;
      ale_o  = 1'b0;
      a35_o  = 3'h0;
      dq_o   = 32'h0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step
   task automatic access(input logic wr, input logic [3:0] adr,
                         input logic [31:0] wd, input int hold);
      ale_o = mux_i | adr[0];
      a35_o = mux_i ? ~adr[3:1] : adr[3:1];
      dq_o[5:2] = adr;
      cs_n_o = 1'b0;
      if (mux_i) begin
         step(6);
         ale_o = 1'b0;
         step(6);
      end
      we_n_o = ~wr;
      oe_n_o = wr;
      dq_o = wr ? wd : ~dq_o;
      step(hold);
      we_n_o = 1'b1;
      oe_n_o = 1'b1;
      step(1);
      cs_n_o = 1'b1;
      dq_o = ~dq_o;
      a35_o = ~a35_o;
      ale_o = mux_i ? 1'b0 : ~ale_o;
      step(4);
   endtask : access
endmodule : ahp_host_model
`default_nettype wire

// [dv/ahp_host_port_tb_top.sv]
// Self-checking testbench of the host bus port
`timescale 1ns/10ps
`default_nettype none
module ahp_host_port_tb_top;
   logic        clk_i, rst_n_i, s_mux, s_le, s_wide, mux, le, wide, qsel;
   logic        cs_n, oe_n, we_n, ale, doe, wstb, rstb, bmux, bwide, ble;
   logic        tick;
   wire  [2:0]  irq;
   logic [2:0]  a35;
   logic [3:0]  a, addr, tdir, tout, tin, tpo, toe, tpi, tpd, tpls;
   logic [7:0]  evt;
   logic [23:0] isel;
   logic [31:0] d, hdq, dq, dout, wdat, rdat;
   logic [67:0] w;
   logic [63:0] r;
   logic [67:0] wq[$];
   logic [63:0] rq[$];
   logic [1:0]  rp;
   int          n_mismatch, n_checks, seed;
   assign dq = doe ? dout : hdq;
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   ahp_host_model host (.clk_i(clk_i), .mux_i(mux), .cs_n_o(cs_n),
      .oe_n_o(oe_n), .we_n_o(we_n), .ale_o(ale), .a35_o(a35), .dq_o(hdq));
   ahp_host_port DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .bus_mux_select_i(s_mux), .byte_order_select_i(s_le),
      .width_select_i(s_wide), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n),
      .write_en_n_i(we_n), .addr_bit2_or_latch_i(ale),
      .addr_bit3_line_i(a35), .data_i(dq), .data_o(dout), .data_oe_o(doe),
      .queue_sel_i(qsel), .addr_o(addr), .wr_strobe_o(wstb),
      .wr_data_o(wdat), .rd_strobe_o(rstb), .rd_data_i(rdat),
      .bus_mux_o(bmux), .bus_wide_o(bwide), .little_endian_o(ble),
      .event_i(evt), .irq_select_i(isel), .host_irq_0_o(irq[0]),
      .host_irq_1_o(irq[1]), .host_irq_2_o(irq[2]),
      .timebase_dir_out_i(tdir), .timebase_pin_out_i(tout),
      .timebase_pin_i(tin), .timebase_pin_o(tpo), .timebase_pin_oe_o(toe),
      .timebase_pin_in_o(tpi), .timebase_tick_i(tick),
      .timebase_pulse_d_i(tpd), .timebase_pulse_out_o(tpls));
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step
   task automatic chk(input logic [31:0] g, e, m);
      n_checks++;
      if ((g & m) !== (e & m)) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [31:0] lanes(input logic [31:0] v);
      if (!qsel) return {16'h0000, v[15:0]};
      if (le) return v;
      if (wide) return {v[7:0], v[15:8], v[23:16], v[31:24]};
      return {16'h0000, v[7:0], v[15:8]};
   endfunction : lanes
   function automatic logic [31:0] msk();
      return (wide && qsel) ? 32'hffffffff : 32'h0000ffff;
   endfunction : msk
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic drain();
      int i;
      for (i = 0; i < 40 && (wq.size() + rq.size()) > 0; i++) step(1);
      if (i == 40) begin
         n_mismatch++;
         $display("BAD %0t no strobe", $time);
         final_report();
      end
   endtask : drain
   // Result watcher
   always @(posedge clk_i) begin
      rp <= {rp[0], rstb};
      if (wstb === 1'b1) begin
         chk(wq.size(), 1, 32'hff);
         if (wq.size() > 0) begin
            w = wq.pop_front();
            chk(addr, w[35:32], 32'hf);
            chk(wdat, w[31:0], w[67:36]);
         end
      end
      if (rp[1] === 1'b1) begin
         chk(rq.size(), 1, 32'hff);
         if (rq.size() > 0) begin
            r = rq.pop_front();
            chk(dout, r[31:0], r[63:32]);
            chk(doe, 1, 1);
         end
      end
   end
   initial begin
      seed = 32'ha051;
      n_mismatch = 0;
      n_checks = 0;
      rst_n_i = 1'b0;
      {s_mux, s_le, s_wide, qsel, tick, mux, le, wide} = '0;
      {evt, isel, tdir, tout, tin, tpd, rdat, a, d} = '0;
      for (int m = 0; m < 8; m++) begin
         {mux, wide, le} = m[2:0];
         {s_mux, s_wide, s_le} = m[2:0];
         rst_n_i = 1'b0;
         step(20);
         chk({wstb, rstb, doe, irq, tpls}, 0, 32'h3ff);
         rst_n_i = 1'b1;
         step(2);
         {s_mux, s_wide, s_le} = ~m[2:0];
         step(3);
         chk({bmux, bwide, ble}, m, 32'h7);
         for (int k = 0; k < 4; k++) begin
            qsel = k[0];
            a = 4'($random(seed));
            d = $random(seed);
            rdat = $random(seed);
            wq.push_back({msk(), a, lanes(d)});
            host.access(1'b1, a, d, 8 + k);
            drain();
            rq.push_back({msk(), lanes(rdat)});
            host.access(1'b0, a, 32'h0, 10 + 2 * k);
            drain();
            chk(doe, 0, 1);
         end
         evt = 8'($random(seed));
         isel = 24'($random(seed));
         {tdir, tout, tin, tpd} = 16'($random(seed));
         tick = 1'b1;
         step(1);
         tick = 1'b0;
         step(4);
         for (int i = 0; i < 3; i++) begin
            chk(irq[i], 32'(|(evt & isel[8*i +: 8])), 1);
         end
         chk({toe, tpo, tpi, tpls}, {tdir, tout, tin, tpd}, 32'hffff);
      end
      final_report();
   end
endmodule : ahp_host_port_tb_top
`default_nettype wire
